/* logic/line_state_pkg.sv */
// Shared constants of the line-state and transformer-failure monitor.
// Assumes a 125 MHz system clock and an APB register port.
package line_state_pkg;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LINE_THR_OFS = 8'h04;
  localparam logic [7:0] VT_THR_OFS = 8'h08;
  localparam logic [7:0] NOMINAL_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // Field positions.
  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_MODE_POS = 1;
  localparam int LINE_V_POS = 0;
  localparam int LINE_I_POS = 8;
  localparam int RES_V_POS = 0;
  localparam int RES_I_POS = 8;
  localparam int NEG_V_POS = 16;
  localparam int NEG_I_POS = 24;
  localparam int NOM_I_POS = 16;
  // Values after reset, in percent where a threshold.
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [6:0] LINE_V_RST = 7'h3C;
  localparam logic [6:0] LINE_I_RST = 7'h0A;
  localparam logic [6:0] RES_V_RST = 7'h1E;
  localparam logic [6:0] RES_I_RST = 7'h0A;
  localparam logic [6:0] NEG_V_RST = 7'h0A;
  localparam logic [6:0] NEG_I_RST = 7'h0A;
  localparam logic [15:0] NOM_V_RST = 16'h4000;
  localparam logic [15:0] NOM_I_RST = 16'h4000;
  // Settable ranges.
  localparam logic [6:0] LINE_V_MIN = 7'h0A;
  localparam logic [6:0] LINE_I_MIN = 7'h02;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [6:0] VT_V_MIN = 7'h05;
  localparam logic [6:0] VT_I_MIN = 7'h0A;
  localparam logic [6:0] VT_MAX = 7'h32;
  // Percent scale of the magnitude comparison.
  localparam logic [13:0] PCT_SCALE = 14'h2710;
  // Timing.
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned LIVE_ARM_MS = 200;
  localparam int unsigned PICKUP_MS = 4;
  localparam int unsigned DROPOUT_MS = 200;
  localparam int unsigned LATCH_MS = 100;
  localparam int unsigned LIVE_ARM_CYC = LIVE_ARM_MS * CYC_PER_MS;
  localparam int unsigned PICKUP_CYC = PICKUP_MS * CYC_PER_MS;
  localparam int unsigned DROPOUT_CYC = DROPOUT_MS * CYC_PER_MS;
  localparam int unsigned LATCH_CYC = LATCH_MS * CYC_PER_MS;
  localparam int CNT_W = 25;
  // Failure check mode.
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_ZERO,
    MODE_NEG,
    MODE_SPECIAL
  } vt_mode_type;
  localparam vt_mode_type MODE_RST = MODE_ZERO;
endpackage

/* logic/line_state_vt_monitor.sv */
// Line-state detection and transformer-failure supervision.
// Assumes phasors, strobe and block input come from logic on this clock.
//
// Functional notes
// - Form residual voltage and current phasors.
// - Dead line: all voltages and currents low.
// - Live line: all three voltages high.
// - Per-phase voltage start flags.
// - Per-phase current start flags.
// - Line voltage threshold 10..100 percent, 60.
// - Line current threshold 2..100 percent, 10.
// - Block input disables line decisions.
// - Zero mode: residual V high, I low.
// - Negative mode: neg V high, I low.
// - Special: residual V high, both currents low.
// - Mode select Off/zero/neg/special, default zero.
// - Failure check needs detector enabled, unblocked.
// - Failure flag only goes downstream.
// - Arm after 200 ms live, disarm dead.
// - Failure asserts after 4 ms of conditions.
// - Failure clears 200 ms after conditions cease; timer runs only while line live.
// - Failure over 100 ms latches on dead.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module line_state_vt_monitor #(
  parameter int W = 16,
  parameter int unsigned LIVE_ARM_CYCLES = line_state_pkg::LIVE_ARM_CYC,
  parameter int unsigned PICKUP_CYCLES = line_state_pkg::PICKUP_CYC,
  parameter int unsigned DROPOUT_CYCLES = line_state_pkg::DROPOUT_CYC,
  parameter int unsigned LATCH_CYCLES = line_state_pkg::LATCH_CYC
) (
  // Clock and reset.
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Phase phasors from the estimation stage.
  input wire logic PHASOR_STROBE_I,
  input wire logic signed [W-1:0] PHASE_VOLTAGE_PHASOR_RE_I [3],
  input wire logic signed [W-1:0] PHASE_VOLTAGE_PHASOR_IM_I [3],
  input wire logic signed [W-1:0] PHASE_CURRENT_PHASOR_RE_I [3],
  input wire logic signed [W-1:0] PHASE_CURRENT_PHASOR_IM_I [3],
  // Negative-sequence phasors from the estimation stage.
  input wire logic signed [W-1:0] NEGSEQ_VOLTAGE_PHASOR_RE_I,
  input wire logic signed [W-1:0] NEGSEQ_VOLTAGE_PHASOR_IM_I,
  input wire logic signed [W-1:0] NEGSEQ_CURRENT_PHASOR_RE_I,
  input wire logic signed [W-1:0] NEGSEQ_CURRENT_PHASOR_IM_I,
  // User blocking input.
  input wire logic LINE_DETECT_BLOCK_I,
  // Line-state flags.
  output logic [2:0] PHASE_VOLTAGE_START_O,
  output logic [2:0] PHASE_CURRENT_START_O,
  output logic DEAD_LINE_FLAG_O,
  output logic LIVE_LINE_FLAG_O,
  // Residual phasors and failure flag toward decision logic.
  output logic signed [W+1:0] RESIDUAL_VOLTAGE_PHASOR_RE_O,
  output logic signed [W+1:0] RESIDUAL_VOLTAGE_PHASOR_IM_O,
  output logic signed [W+1:0] RESIDUAL_CURRENT_PHASOR_RE_O,
  output logic signed [W+1:0] RESIDUAL_CURRENT_PHASOR_IM_O,
  output logic VT_FAIL_INTERNAL_O
);
  localparam int CW = line_state_pkg::CNT_W;
  localparam int PW = W + 2;
  localparam int MW = 2 * PW;
  localparam int LW = MW + 16;

  //////////////////////////////////////////////////////////////////////////

  // Squares are compared so no square root is needed; the percent scale is
  // moved to the magnitude side to avoid any division.
  function automatic logic above(input logic signed [PW-1:0] re,
                                 input logic signed [PW-1:0] im,
                                 input logic [6:0] pct,
                                 input logic [15:0] nom);
    logic signed [MW-1:0] a;
    logic signed [MW-1:0] b;
    logic [MW-1:0] m;
    logic [LW-1:0] lhs;
    logic [22:0] s;
    logic [LW-1:0] rhs;
    a = re * re;
    b = im * im;
    m = MW'($unsigned(a)) + MW'($unsigned(b));
    lhs = LW'(m) * LW'(line_state_pkg::PCT_SCALE);
    s = 23'(pct) * 23'(nom);
    rhs = LW'(s) * LW'(s);
    return lhs > rhs;
  endfunction

  function automatic logic [6:0] clamp(input logic [6:0] v,
                                       input logic [6:0] lo,
                                       input logic [6:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [PW-1:0] sum3(
      input logic signed [W-1:0] x0,
      input logic signed [W-1:0] x1,
      input logic signed [W-1:0] x2);
    return PW'(x0) + PW'(x1) + PW'(x2);
  endfunction

  //////////////////////////////////////////////////////////////////////////

  logic en_q;
  line_state_pkg::vt_mode_type mode_q;
  logic [6:0] line_v_q;
  logic [6:0] line_i_q;
  logic [6:0] res_v_q;
  logic [6:0] res_i_q;
  logic [6:0] neg_v_q;
  logic [6:0] neg_i_q;
  logic [15:0] nom_v_q;
  logic [15:0] nom_i_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [2:0] vst_q;
  logic [2:0] ist_q;
  logic dead_q;
  logic live_q;
  logic dead_prev_q;
  logic cond_q;
  logic armed_q;
  logic fail_q;
  logic long_q;
  logic [CW-1:0] live_cnt_q;
  logic [CW-1:0] pick_cnt_q;
  logic [CW-1:0] drop_cnt_q;
  logic [CW-1:0] on_cnt_q;
  logic signed [PW-1:0] rv_re_q;
  logic signed [PW-1:0] rv_im_q;
  logic signed [PW-1:0] ri_re_q;
  logic signed [PW-1:0] ri_im_q;

  //////////////////////////////////////////////////////////////////////////

  // A request is answered one cycle into its access phase.
  wire acc_start = PSEL_I & PENABLE_I & ~pready_q;
  wire acc_done = PSEL_I & PENABLE_I & pready_q;
  wire wr = acc_done & PWRITE_I;
  wire hit_ctrl = PADDR_I == line_state_pkg::CTRL_OFS;
  wire hit_line = PADDR_I == line_state_pkg::LINE_THR_OFS;
  wire hit_vt = PADDR_I == line_state_pkg::VT_THR_OFS;
  wire hit_nom = PADDR_I == line_state_pkg::NOMINAL_OFS;
  wire hit_stat = PADDR_I == line_state_pkg::STATUS_OFS;
  wire hit_any = hit_ctrl | hit_line | hit_vt | hit_nom | hit_stat;
  wire bad = ~hit_any | (PWRITE_I & hit_stat);
  wire [31:0] rd_ctrl = {29'h0, 2'(mode_q), en_q};
  wire [31:0] rd_line = {17'h0, line_i_q, 1'b0, line_v_q};
  wire [31:0] rd_vt = {1'b0, neg_i_q, 1'b0, neg_v_q,
                       1'b0, res_i_q, 1'b0, res_v_q};
  wire [31:0] rd_nom = {nom_i_q, nom_v_q};
  wire [31:0] rd_stat = {22'h0, ~LINE_DETECT_BLOCK_I & en_q, armed_q,
                         live_q, dead_q, ist_q, vst_q};
  wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
                        hit_line ? rd_line :
                        hit_vt ? rd_vt :
                        hit_nom ? rd_nom :
                        hit_stat ? rd_stat : 32'h0;

  wire [6:0] wr_line_v = clamp(PWDATA_I[line_state_pkg::LINE_V_POS +: 7],
                               line_state_pkg::LINE_V_MIN,
                               line_state_pkg::PCT_MAX);
  wire [6:0] wr_line_i = clamp(PWDATA_I[line_state_pkg::LINE_I_POS +: 7],
                               line_state_pkg::LINE_I_MIN,
                               line_state_pkg::PCT_MAX);
  wire [6:0] wr_res_v = clamp(PWDATA_I[line_state_pkg::RES_V_POS +: 7],
                              line_state_pkg::VT_V_MIN,
                              line_state_pkg::VT_MAX);
  wire [6:0] wr_res_i = clamp(PWDATA_I[line_state_pkg::RES_I_POS +: 7],
                              line_state_pkg::VT_I_MIN,
                              line_state_pkg::VT_MAX);
  wire [6:0] wr_neg_v = clamp(PWDATA_I[line_state_pkg::NEG_V_POS +: 7],
                              line_state_pkg::VT_V_MIN,
                              line_state_pkg::VT_MAX);
  wire [6:0] wr_neg_i = clamp(PWDATA_I[line_state_pkg::NEG_I_POS +: 7],
                              line_state_pkg::VT_I_MIN,
                              line_state_pkg::VT_MAX);

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc_start;
      pslverr_q <= acc_start & bad;
      prdata_q <= (acc_start & ~PWRITE_I) ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      en_q <= line_state_pkg::CTRL_EN_RST;
      mode_q <= line_state_pkg::MODE_RST;
    end else if (wr & hit_ctrl) begin
      en_q <= PWDATA_I[line_state_pkg::CTRL_EN_POS];
      mode_q <= line_state_pkg::vt_mode_type'(
                  PWDATA_I[line_state_pkg::CTRL_MODE_POS +: 2]);
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      line_v_q <= line_state_pkg::LINE_V_RST;
      line_i_q <= line_state_pkg::LINE_I_RST;
    end else if (wr & hit_line) begin
      line_v_q <= wr_line_v;
      line_i_q <= wr_line_i;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      res_v_q <= line_state_pkg::RES_V_RST;
      res_i_q <= line_state_pkg::RES_I_RST;
      neg_v_q <= line_state_pkg::NEG_V_RST;
      neg_i_q <= line_state_pkg::NEG_I_RST;
    end else if (wr & hit_vt) begin
      res_v_q <= wr_res_v;
      res_i_q <= wr_res_i;
      neg_v_q <= wr_neg_v;
      neg_i_q <= wr_neg_i;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      nom_v_q <= line_state_pkg::NOM_V_RST;
      nom_i_q <= line_state_pkg::NOM_I_RST;
    end else if (wr & hit_nom) begin
      nom_v_q <= PWDATA_I[15:0];
      nom_i_q <= PWDATA_I[line_state_pkg::NOM_I_POS +: 16];
    end
  end

  //////////////////////////////////////////////////////////////////////////

  wire active = en_q & ~LINE_DETECT_BLOCK_I;

  wire signed [PW-1:0] rv_re = sum3(PHASE_VOLTAGE_PHASOR_RE_I[0],
    PHASE_VOLTAGE_PHASOR_RE_I[1], PHASE_VOLTAGE_PHASOR_RE_I[2]);
  wire signed [PW-1:0] rv_im = sum3(PHASE_VOLTAGE_PHASOR_IM_I[0],
    PHASE_VOLTAGE_PHASOR_IM_I[1], PHASE_VOLTAGE_PHASOR_IM_I[2]);
  wire signed [PW-1:0] ri_re = sum3(PHASE_CURRENT_PHASOR_RE_I[0],
    PHASE_CURRENT_PHASOR_RE_I[1], PHASE_CURRENT_PHASOR_RE_I[2]);
  wire signed [PW-1:0] ri_im = sum3(PHASE_CURRENT_PHASOR_IM_I[0],
    PHASE_CURRENT_PHASOR_IM_I[1], PHASE_CURRENT_PHASOR_IM_I[2]);

  logic [2:0] vst_d;
  logic [2:0] ist_d;
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      vst_d[p] = above(PW'(PHASE_VOLTAGE_PHASOR_RE_I[p]),
                       PW'(PHASE_VOLTAGE_PHASOR_IM_I[p]), line_v_q, nom_v_q);
      ist_d[p] = above(PW'(PHASE_CURRENT_PHASOR_RE_I[p]),
                       PW'(PHASE_CURRENT_PHASOR_IM_I[p]), line_i_q, nom_i_q);
    end
  end

  // sequence compares; equal counts as not above.
  wire res_v_hi = above(rv_re, rv_im, res_v_q, nom_v_q);
  wire res_i_hi = above(ri_re, ri_im, res_i_q, nom_i_q);
  wire neg_v_hi = above(PW'(NEGSEQ_VOLTAGE_PHASOR_RE_I),
                        PW'(NEGSEQ_VOLTAGE_PHASOR_IM_I), neg_v_q, nom_v_q);
  wire neg_i_hi = above(PW'(NEGSEQ_CURRENT_PHASOR_RE_I),
                        PW'(NEGSEQ_CURRENT_PHASOR_IM_I), neg_i_q, nom_i_q);

  logic mode_cond;
  always_comb begin
    case (mode_q)
      line_state_pkg::MODE_ZERO: mode_cond = res_v_hi & ~res_i_hi;
      line_state_pkg::MODE_NEG: mode_cond = neg_v_hi & ~neg_i_hi;
      line_state_pkg::MODE_SPECIAL:
        mode_cond = res_v_hi & ~res_i_hi & ~neg_i_hi;
      default: mode_cond = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      vst_q <= 3'h0;
      ist_q <= 3'h0;
      dead_q <= 1'b0;
      live_q <= 1'b0;
    end else if (!active) begin
      vst_q <= 3'h0;
      ist_q <= 3'h0;
      dead_q <= 1'b0;
      live_q <= 1'b0;
    end else if (PHASOR_STROBE_I) begin
      vst_q <= vst_d;
      ist_q <= ist_d;
      dead_q <= ~|vst_d & ~|ist_d;
      live_q <= &vst_d;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rv_re_q <= '0;
      rv_im_q <= '0;
      ri_re_q <= '0;
      ri_im_q <= '0;
      cond_q <= 1'b0;
    end else begin
      if (PHASOR_STROBE_I) begin
        rv_re_q <= rv_re;
        rv_im_q <= rv_im;
        ri_re_q <= ri_re;
        ri_im_q <= ri_im;
      end
      if (!armed_q) begin
        cond_q <= 1'b0;
      end else if (PHASOR_STROBE_I) begin
        cond_q <= mode_cond;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      live_cnt_q <= '0;
      armed_q <= 1'b0;
    end else if (!active || dead_q) begin
      live_cnt_q <= '0;
      armed_q <= 1'b0;
    end else if (live_q && !armed_q) begin
      live_cnt_q <= live_cnt_q + 1'b1;
      if (live_cnt_q == CW'(LIVE_ARM_CYCLES - 1)) begin
        armed_q <= 1'b1;
      end
    end else begin
      live_cnt_q <= '0;
    end
  end

  wire pick_done = pick_cnt_q == CW'(PICKUP_CYCLES - 1);
  wire drop_run = fail_q & ~cond_q & live_q;
  wire drop_done = drop_run & (drop_cnt_q == CW'(DROPOUT_CYCLES - 1));
  wire dead_rise = dead_q & ~dead_prev_q;

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pick_cnt_q <= '0;
      drop_cnt_q <= '0;
      dead_prev_q <= 1'b0;
    end else begin
      dead_prev_q <= dead_q;
      pick_cnt_q <= (cond_q & ~fail_q) ? pick_cnt_q + 1'b1 : '0;
      drop_cnt_q <= drop_run ? drop_cnt_q + 1'b1 : '0;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      on_cnt_q <= '0;
      long_q <= 1'b0;
    end else if (!fail_q) begin
      on_cnt_q <= '0;
      long_q <= 1'b0;
    end else if (!long_q) begin
      on_cnt_q <= on_cnt_q + 1'b1;
      long_q <= on_cnt_q == CW'(LATCH_CYCLES - 1);
    end
  end

  // A latched failure survives the dead interval so that it is still
  // present at reclosing; only a disable or the live dropout clears it.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fail_q <= 1'b0;
    end else if (!active || mode_q == line_state_pkg::MODE_OFF) begin
      fail_q <= 1'b0;
    end else if (!fail_q) begin
      fail_q <= cond_q & pick_done;
    end else if (dead_rise && !long_q) begin
      fail_q <= 1'b0;
    end else if (drop_done) begin
      fail_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PHASE_VOLTAGE_START_O = vst_q;
  assign PHASE_CURRENT_START_O = ist_q;
  assign DEAD_LINE_FLAG_O = dead_q;
  assign LIVE_LINE_FLAG_O = live_q;
  assign RESIDUAL_VOLTAGE_PHASOR_RE_O = rv_re_q;
  assign RESIDUAL_VOLTAGE_PHASOR_IM_O = rv_im_q;
  assign RESIDUAL_CURRENT_PHASOR_RE_O = ri_re_q;
  assign RESIDUAL_CURRENT_PHASOR_IM_O = ri_im_q;
  // failure goes to a port, not a register.
  assign VT_FAIL_INTERNAL_O = fail_q;
endmodule
`default_nettype wire

/* sim/line_state_vt_monitor_props.sv */
// Port assertions for the line-state and failure monitor.
// Assumes binding into each monitor.
`timescale 1ns/1ns
`default_nettype none
module line_state_vt_checker #(
  parameter int W = 16,
  parameter int unsigned LIVE_ARM_CYCLES = 40,
  parameter int unsigned PICKUP_CYCLES = 8
) (
  // Clock and reset.
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // APB.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Line side.
  input wire logic PHASOR_STROBE_I,
  input wire logic signed [W-1:0] PHASE_VOLTAGE_PHASOR_RE_I [3],
  input wire logic LINE_DETECT_BLOCK_I,
  input wire logic [2:0] PHASE_VOLTAGE_START_O,
  input wire logic [2:0] PHASE_CURRENT_START_O,
  input wire logic DEAD_LINE_FLAG_O,
  input wire logic LIVE_LINE_FLAG_O,
  input wire logic signed [W+1:0] RESIDUAL_VOLTAGE_PHASOR_RE_O,
  input wire logic VT_FAIL_INTERNAL_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////////////////////////////////////////
  // Age since reset saturates, so it never wraps back under the arm time.
  logic [25:0] age_q;
  logic [25:0] age_d;
  logic signed [W+1:0] res_sum;
  assign age_d = age_q[25] ? age_q : age_q + 26'h0000001;
  assign res_sum = PHASE_VOLTAGE_PHASOR_RE_I[0]
    + PHASE_VOLTAGE_PHASOR_RE_I[1] + PHASE_VOLTAGE_PHASOR_RE_I[2];
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      age_q <= 26'h0000000;
    end else begin
      age_q <= age_d;
    end
  end
  sequence access_first;
    PSEL_I && $rose(PENABLE_I);
  endsequence
  sequence answer_pulse;
    !PREADY_O ##1 PREADY_O ##1 !PREADY_O;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_ready_wait: assert property (access_first |-> answer_pulse)
    else $error("ready late");
  chk_unmapped_err: assert property (PREADY_O && PADDR_I > 8'h10
    |-> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("no error");
  chk_idle_rdata: assert property (!PREADY_O
    |-> PRDATA_O == 32'h0 && !PSLVERR_O)
    else $error("stray data");
  chk_residual_sum: assert property (
    $past(PHASOR_STROBE_I) |-> RESIDUAL_VOLTAGE_PHASOR_RE_O == $past(res_sum))
    else $error("bad residual");
  chk_dead_all_low: assert property (DEAD_LINE_FLAG_O
    |-> PHASE_VOLTAGE_START_O == 3'h0 && PHASE_CURRENT_START_O == 3'h0
    && !LIVE_LINE_FLAG_O)
    else $error("dead with start");
  chk_live_all_high: assert property (
    LIVE_LINE_FLAG_O |-> PHASE_VOLTAGE_START_O == 3'h7)
    else $error("live without V");
  chk_block_clears: assert property (LINE_DETECT_BLOCK_I
    |=> PHASE_VOLTAGE_START_O == 3'h0 && PHASE_CURRENT_START_O == 3'h0
    && !DEAD_LINE_FLAG_O && !LIVE_LINE_FLAG_O)
    else $error("flags while blocked");
  chk_block_no_fail: assert property (
    LINE_DETECT_BLOCK_I |-> ##[1:2] !VT_FAIL_INTERNAL_O)
    else $error("fail while blocked");
  chk_flags_hold: assert property (
    !PHASOR_STROBE_I && !LINE_DETECT_BLOCK_I && !PSEL_I && !$past(PSEL_I)
    |=> $stable(PHASE_VOLTAGE_START_O) && $stable(LIVE_LINE_FLAG_O))
    else $error("flags moved");
  chk_fail_after_arm: assert property (
    $rose(VT_FAIL_INTERNAL_O) |-> age_q >= LIVE_ARM_CYCLES + PICKUP_CYCLES)
    else $error("fail too early");
endmodule
bind line_state_vt_monitor line_state_vt_checker #(
  .W(W),
  .LIVE_ARM_CYCLES(LIVE_ARM_CYCLES),
  .PICKUP_CYCLES(PICKUP_CYCLES)
) line_state_vt_checker_i (
  .SYS_CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PADDR_I, .PRDATA_O,
  .PREADY_O, .PSLVERR_O, .PHASOR_STROBE_I, .PHASE_VOLTAGE_PHASOR_RE_I,
  .LINE_DETECT_BLOCK_I, .PHASE_VOLTAGE_START_O, .PHASE_CURRENT_START_O,
  .DEAD_LINE_FLAG_O, .LIVE_LINE_FLAG_O, .RESIDUAL_VOLTAGE_PHASOR_RE_O,
  .VT_FAIL_INTERNAL_O
);
`default_nettype wire

/* sim/line_state_vt_monitor_tb_top.sv */
// Self-checking bench of the line-state and failure monitor.
// Assumes the bound checker and the phasor source model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) cmp(32'(g), 32'(e))
module line_state_vt_monitor_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, block = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, strobe, dead, live, fail;
  logic signed [15:0] volt = 0, skew = 0, cur = 0, negv = 0, negi = 0;
  logic signed [15:0] v_re [3], v_im [3], i_re [3], i_im [3], nv, ni;
  logic [2:0] vst, ist;
  logic signed [17:0] rv_re;
  int fail_count = 0, checks = 0, n;
  logic [7:0] ofs [5] = '{line_state_pkg::CTRL_OFS,
    line_state_pkg::LINE_THR_OFS, line_state_pkg::VT_THR_OFS,
    line_state_pkg::NOMINAL_OFS, line_state_pkg::STATUS_OFS};
  logic [31:0] dflt [4] = '{32'h3, 32'hA3C, 32'h0A0A0A1E, 32'h40004000};
  int lv [5] = '{12000, 12000, 1000, 1000, 12000};
  int ls [5] = '{0, 0, 0, 0, -8000};
  int lc [5] = '{3000, 1000, 3000, 0, 3000};
  logic [7:0] lf [5] = '{8'hFD, 8'hE1, 8'h1C, 8'h02, 8'hDC};
  int md [7] = '{0, 2, 2, 3, 3, 1, 1};
  int ms [7] = '{-8000, 0, -8000, -8000, -8000, 0, -8000};
  int mv [7] = '{0, 3000, 0, 0, 0, 3000, 0};
  int mi [7] = '{0, 0, 0, 0, 3000, 0, 0};
  logic mx [7] = '{0, 1, 0, 1, 0, 0, 1};
  line_state_vt_monitor #(.LIVE_ARM_CYCLES(40), .PICKUP_CYCLES(8),
    .DROPOUT_CYCLES(40), .LATCH_CYCLES(20)) line_state_vt_monitor_i (
    .SYS_CLK_I(sys_clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .PHASOR_STROBE_I(strobe), .PHASE_VOLTAGE_PHASOR_RE_I(v_re),
    .PHASE_VOLTAGE_PHASOR_IM_I(v_im), .PHASE_CURRENT_PHASOR_RE_I(i_re),
    .PHASE_CURRENT_PHASOR_IM_I(i_im), .NEGSEQ_VOLTAGE_PHASOR_RE_I(nv),
    .NEGSEQ_VOLTAGE_PHASOR_IM_I(nv), .NEGSEQ_CURRENT_PHASOR_RE_I(ni),
    .NEGSEQ_CURRENT_PHASOR_IM_I(ni), .LINE_DETECT_BLOCK_I(block),
    .PHASE_VOLTAGE_START_O(vst), .PHASE_CURRENT_START_O(ist),
    .DEAD_LINE_FLAG_O(dead), .LIVE_LINE_FLAG_O(live),
    .RESIDUAL_VOLTAGE_PHASOR_RE_O(rv_re), .RESIDUAL_VOLTAGE_PHASOR_IM_O(),
    .RESIDUAL_CURRENT_PHASOR_RE_O(), .RESIDUAL_CURRENT_PHASOR_IM_O(),
    .VT_FAIL_INTERNAL_O(fail));
  phasor_source phasor_source_i (.clk_i(sys_clk), .rst_i(rst),
    .volt_i(volt), .skew_i(skew), .cur_i(cur), .negv_i(negv),
    .negi_i(negi), .strobe_o(strobe), .v_re_o(v_re), .v_im_o(v_im),
    .i_re_o(i_re), .i_im_o(i_im), .nv_re_o(nv), .ni_re_o(ni));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Holds the request until ready, then idles a cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && t < 20) begin
      @(posedge sys_clk);
      t++;
    end
    if (t == 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic feed(input int v = 12000, s = 0, c = 3000, nvv = 0,
      niv = 0);
    volt <= 16'(v);
    skew <= 16'(s);
    cur <= 16'(c);
    negv <= 16'(nvv);
    negi <= 16'(niv);
  endtask
  task automatic wait_fail();
    n = 0;
    while (fail !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    cyc(20000);
    fail_count++;
    conclude();
  end
  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, ofs[k], 32'h0);
      `CHK(rd, dflt[k]);
    end
    apb(1'b1, ofs[1], 32'h7F05);
    apb(1'b0, ofs[1], 32'h0);
    `CHK(rd, 32'h640A);
    apb(1'b1, ofs[2], 32'h7F017F01);
    apb(1'b0, ofs[2], 32'h0);
    `CHK(rd, 32'h32053205);
    apb(1'b1, ofs[1], dflt[1]);
    apb(1'b1, ofs[2], dflt[2]);
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, ofs[4], 32'hFFFFFFFF);
    `CHK(err, 1'b1);
    apb(1'b0, ofs[4], 32'h0);
    `CHK(rd, 32'h240);
    for (int k = 0; k < 5; k++) begin
      feed(lv[k], ls[k], lc[k]);
      cyc(8);
      `CHK({vst, ist, dead, live}, lf[k]);
      `CHK(rv_re, ls[k]);
    end
    feed();
    cyc(60);
    apb(1'b0, ofs[4], 32'h0);
    `CHK(rd, 32'h3BF);
    feed(12000, -8000);
    cyc(4);
    `CHK(fail, 1'b0);
    wait_fail();
    `CHK(n <= 12, 1'b1);
    cyc(24);
    feed(1000, 0, 0);
    cyc(10);
    `CHK({dead, fail}, 2'b11);
    feed();
    cyc(10);
    `CHK(fail, 1'b1);
    cyc(40);
    `CHK(fail, 1'b0);
    cyc(60);
    feed(12000, -8000);
    wait_fail();
    feed(1000, 0, 0);
    cyc(10);
    `CHK({dead, fail}, 2'b10);
    apb(1'b0, ofs[4], 32'h0);
    `CHK(rd, 32'h240);
    feed();
    cyc(60);
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, ofs[0], {29'h0, md[k][1:0], 1'b1});
      feed(12000, ms[k], 3000, mv[k], mi[k]);
      cyc(24);
      `CHK(fail, mx[k]);
      feed();
      cyc(64);
    end
    feed(12000, -8000);
    wait_fail();
    block <= 1'b1;
    cyc(3);
    `CHK({vst, ist, dead, live, fail}, 9'h0);
    apb(1'b0, ofs[4], 32'h0);
    `CHK(rd[9], 1'b0);
    block <= 1'b0;
    feed();
    cyc(10);
    apb(1'b1, ofs[0], 32'h2);
    cyc(3);
    `CHK({vst, ist, dead, live, fail}, 9'h0);
    apb(1'b1, ofs[0], 32'h3);
    conclude();
  end
endmodule
`default_nettype wire

/* sim/phasor_source.sv */
// Model of the phasor estimation stage feeding the monitor.
// Assumes the bench sets magnitudes just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module phasor_source (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Scenario settings.
  input wire logic signed [15:0] volt_i,
  input wire logic signed [15:0] skew_i,
  input wire logic signed [15:0] cur_i,
  input wire logic signed [15:0] negv_i,
  input wire logic signed [15:0] negi_i,
  // Phasor feed.
  output logic strobe_o,
  output logic signed [15:0] v_re_o [3],
  output logic signed [15:0] v_im_o [3],
  output logic signed [15:0] i_re_o [3],
  output logic signed [15:0] i_im_o [3],
  output logic signed [15:0] nv_re_o,
  output logic signed [15:0] ni_re_o
);
  // A balanced set sums to zero, so the residual equals the skew alone.
  logic [1:0] cnt_q;
  logic signed [31:0] vh;
  logic signed [31:0] ih;
  assign vh = (32'(volt_i) * 887) >>> 10;
  assign ih = (32'(cur_i) * 887) >>> 10;
  assign v_re_o = '{volt_i + skew_i, -(volt_i >>> 1), -(volt_i >>> 1)};
  assign v_im_o = '{16'sh0000, vh[15:0], -vh[15:0]};
  assign i_re_o = '{cur_i, -(cur_i >>> 1), -(cur_i >>> 1)};
  assign i_im_o = '{16'sh0000, ih[15:0], -ih[15:0]};
  assign nv_re_o = negv_i;
  assign ni_re_o = negi_i;
  assign strobe_o = (cnt_q == 2'h3);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule
`default_nettype wire
